// ### shared/cfg_loader_defines.svh
`ifndef CFG_LOADER_DEFINES_SVH
`define CFG_LOADER_DEFINES_SVH

// ==========================================================
// Register map and command key
`define SOFT_RESET_ADDR 5'h0a
`define SOFT_RESET_KEY 8'h5a

// ==========================================================
// Timing field reset values
`define DFLT_ALIGNER_BYPASS 1'b1
`define DFLT_HALF_PERIOD 1'b0
`define DFLT_DATA_DELAY 3'h6
`define DFLT_CLOCK_DELAY 3'h6

// ==========================================================
// Reset duration: 85 us at 10 ns period, fixed count of clock periods
`define RESET_TIME_NS 85000
`define REF_PERIOD_NS 10
`define RESET_CYCLES (`RESET_TIME_NS / `REF_PERIOD_NS)

// ==========================================================
// Timing field codes
`define DELAY_NOMINAL 3'h0
`define DELAY_NEG_BIT 2

`endif

// ### shared/cfg_loader_pkg.sv
package cfg_loader_pkg;

  // ==========================================================
  // Timing control fields
  typedef struct packed {
    logic aligner_bypass;
    logic half_period_delay;
    logic [2:0] data_delay_sel;
    logic [2:0] out_clock_delay_sel;
  } timing_cfg_t;

  // ==========================================================
  // Serial register write strobe with address and data
  typedef struct packed {
    logic valid;
    logic [4:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef enum logic [1:0] {
    ST_WAIT_POWER,
    ST_LOADING,
    ST_RUN
  } load_state_t;

endpackage : cfg_loader_pkg

// ### logic/register_reset_and_output_timing_cfg.sv
`timescale 1ns/1ps
`include "cfg_loader_defines.svh"

module register_reset_and_output_timing_cfg #(
  parameter int unsigned RESET_CYCLES = `RESET_CYCLES,
  parameter logic [7:0] CFG_ADDR = 8'h07
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_en,
  input wire logic analog_supply,
  input wire logic serial_port_disable,
  input wire logic power_down_pin,
  input wire logic mux_mode,
  input wire cfg_loader_pkg::reg_write_t wr,
  input wire cfg_loader_pkg::timing_cfg_t nv_defaults,
  output cfg_loader_pkg::timing_cfg_t timing_ff,
  output logic half_delay_eff_ff,
  output logic reset_busy_ff,
  output logic order_error_ff
);

  // ==========================================================
  // State
  cfg_loader_pkg::load_state_t state_ff, nxt_state;
  cfg_loader_pkg::timing_cfg_t nxt_timing;
  logic [31:0] count_ff, nxt_count;
  logic pd_prev_ff, nxt_pd_prev;
  logic nxt_busy, nxt_half_eff, nxt_order_err;
  logic soft_hit, hard_hit, wr_ok;

  // Signed sixteenths of the period for ordering comparison
  function automatic logic signed [2:0] delay_val(input logic [2:0] c);
    if (c[`DELAY_NEG_BIT])
      delay_val = -$signed({1'b0, c[1:0]});
    else
      delay_val = $signed({1'b0, c[1:0]});
  endfunction : delay_val

  // ==========================================================
  // Next state
  always_comb begin
    nxt_state = state_ff;
    nxt_timing = timing_ff;
    nxt_count = count_ff;
    nxt_pd_prev = power_down_pin;
    // Serial writes are ignored while pins own configuration
    wr_ok = wr.valid && !serial_port_disable;
    soft_hit = wr_ok && wr.addr == `SOFT_RESET_ADDR &&
      wr.data == `SOFT_RESET_KEY;
    hard_hit = serial_port_disable && pd_prev_ff && !power_down_pin;
    unique case (state_ff)
      cfg_loader_pkg::ST_WAIT_POWER: begin
        // Reaching here at all implies the clock runs
        if (analog_supply) begin
          nxt_state = cfg_loader_pkg::ST_LOADING;
          nxt_count = 32'h0;
        end
      end
      cfg_loader_pkg::ST_LOADING: begin
        nxt_timing = nv_defaults;
        if (soft_hit || hard_hit)
          nxt_count = 32'h0;
        else if (count_ff >= RESET_CYCLES - 1)
          nxt_state = cfg_loader_pkg::ST_RUN;
        else
          nxt_count = count_ff + 32'h1;
      end
      cfg_loader_pkg::ST_RUN: begin
        if (soft_hit || hard_hit) begin
          nxt_state = cfg_loader_pkg::ST_LOADING;
          nxt_count = 32'h0;
        end else if (wr_ok && wr.addr == CFG_ADDR[4:0]) begin
          // Config byte maps onto the struct bit for bit
          nxt_timing = cfg_loader_pkg::timing_cfg_t'(wr.data);
        end
      end
    endcase
    if (!analog_supply)
      nxt_state = cfg_loader_pkg::ST_WAIT_POWER;
    nxt_busy = nxt_state != cfg_loader_pkg::ST_RUN;
    nxt_half_eff = nxt_timing.half_period_delay && !mux_mode;
    // Flag an ordering that the capture side cannot use
    nxt_order_err = nxt_timing.aligner_bypass &&
      delay_val(nxt_timing.out_clock_delay_sel) >
      delay_val(nxt_timing.data_delay_sel);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= cfg_loader_pkg::ST_WAIT_POWER;
      timing_ff <= {`DFLT_ALIGNER_BYPASS, `DFLT_HALF_PERIOD,
        `DFLT_DATA_DELAY, `DFLT_CLOCK_DELAY};
      count_ff <= 32'h0;
      pd_prev_ff <= 1'b0;
      reset_busy_ff <= 1'b1;
      half_delay_eff_ff <= 1'b0;
      order_error_ff <= 1'b0;
    end else if (clock_en) begin
      state_ff <= nxt_state;
      timing_ff <= nxt_timing;
      count_ff <= nxt_count;
      pd_prev_ff <= nxt_pd_prev;
      reset_busy_ff <= nxt_busy;
      half_delay_eff_ff <= nxt_half_eff;
      order_error_ff <= nxt_order_err;
    end
  end

  // ==========================================================
  // Checks
  a_soft_reset_start: assert property (@(posedge clock) disable iff (!rst_n)
    clock_en && analog_supply && state_ff == cfg_loader_pkg::ST_RUN &&
    soft_hit |=> reset_busy_ff)
    else $error("soft reset key did not start reset");
  a_bad_key_ignored: assert property (@(posedge clock) disable iff (!rst_n)
    clock_en && analog_supply && state_ff == cfg_loader_pkg::ST_RUN &&
    wr.valid && wr.addr == `SOFT_RESET_ADDR && !hard_hit &&
    wr.data != `SOFT_RESET_KEY |=> !reset_busy_ff)
    else $error("non key write started reset");
  a_hard_reset_start: assert property (@(posedge clock) disable iff (!rst_n)
    clock_en && analog_supply && hard_hit |=> reset_busy_ff)
    else $error("shutdown edge did not start reset");
  a_power_on_load: assert property (@(posedge clock) disable iff (!rst_n)
    clock_en && analog_supply && state_ff == cfg_loader_pkg::ST_WAIT_POWER
    |=> state_ff == cfg_loader_pkg::ST_LOADING)
    else $error("power on load did not start");
  a_defaults_loaded: assert property (@(posedge clock) disable iff (!rst_n)
    clock_en && analog_supply && state_ff == cfg_loader_pkg::ST_LOADING
    |=> timing_ff == $past(nv_defaults))
    else $error("defaults not loaded during reset");
  a_hold_in_run: assert property (@(posedge clock) disable iff (!rst_n)
    state_ff == cfg_loader_pkg::ST_RUN && !$past(wr.valid) &&
    $past(state_ff) == cfg_loader_pkg::ST_RUN |-> $stable(timing_ff))
    else $error("timing changed without write");
  a_reset_length: assert property (@(posedge clock) disable iff (!rst_n)
    state_ff == cfg_loader_pkg::ST_LOADING && count_ff >= RESET_CYCLES - 1
    && clock_en && analog_supply && !soft_hit && !hard_hit
    |=> !reset_busy_ff)
    else $error("reset did not end at count");
  a_count_bound: assert property (@(posedge clock) disable iff (!rst_n)
    count_ff < RESET_CYCLES)
    else $error("reset counter overran");
  a_mux_no_half: assert property (@(posedge clock) disable iff (!rst_n)
    clock_en && mux_mode |=> !half_delay_eff_ff)
    else $error("half period delay active in mux mode");
  a_pins_own_cfg: assert property (@(posedge clock) disable iff (!rst_n)
    serial_port_disable && state_ff == cfg_loader_pkg::ST_RUN &&
    analog_supply && !hard_hit |=> $stable(timing_ff))
    else $error("serial write took effect with port disabled");

  // ==========================================================
  // Reset restart sequences
  sequence s_key_in_run;
    clock_en && analog_supply && state_ff == cfg_loader_pkg::ST_RUN &&
      soft_hit;
  endsequence

  sequence s_edge_in_run;
    clock_en && analog_supply && state_ff == cfg_loader_pkg::ST_RUN &&
      hard_hit;
  endsequence

  // Count restarts from zero so the full duration always elapses
  sequence s_reload;
    reset_busy_ff && count_ff == 32'h0;
  endsequence

  a_key_restarts: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_key_in_run |=> s_reload)
    else $error("soft key did not restart the count");
  a_edge_restarts: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_edge_in_run |=> s_reload)
    else $error("shutdown edge did not restart the count");
  a_reload_defaults: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_key_in_run ##1 (clock_en && analog_supply)
    |=> timing_ff == $past(nv_defaults))
    else $error("soft reset did not reload defaults");

  // ==========================================================
  // Flag and state checks
  a_supply_loss: assert property (
    @(posedge clock) disable iff (!rst_n)
    clock_en && !analog_supply
    |=> state_ff == cfg_loader_pkg::ST_WAIT_POWER && reset_busy_ff)
    else $error("supply loss did not return to wait");
  a_busy_not_run: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_ff != cfg_loader_pkg::ST_RUN |-> reset_busy_ff)
    else $error("busy low outside run");
  a_freeze_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    !clock_en |=> $stable(timing_ff) && $stable(state_ff))
    else $error("state moved while clock enable low");
  a_no_order_off: assert property (
    @(posedge clock) disable iff (!rst_n)
    !timing_ff.aligner_bypass |-> !order_error_ff)
    else $error("order flag set with bypass off");
  a_equal_delays_ok: assert property (
    @(posedge clock) disable iff (!rst_n)
    timing_ff.out_clock_delay_sel == timing_ff.data_delay_sel
    |-> !order_error_ff)
    else $error("order flag set for equal delays");
  a_late_clock_flag: assert property (
    @(posedge clock) disable iff (!rst_n)
    timing_ff.aligner_bypass && timing_ff.data_delay_sel == 3'h7 &&
    timing_ff.out_clock_delay_sel != 3'h7 |-> order_error_ff)
    else $error("late clock delay not flagged");
  a_half_follows: assert property (
    @(posedge clock) disable iff (!rst_n)
    clock_en && !mux_mode
    |=> half_delay_eff_ff == timing_ff.half_period_delay)
    else $error("half period delay lost outside mux mode");

endmodule : register_reset_and_output_timing_cfg

// ### verif/serial_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Serial host: one-cycle write strobe
module serial_host_model (
  input wire logic clock,
  output cfg_loader_pkg::reg_write_t wr
);
  initial wr = '0;

  // Idle bus shows flipped bits so a stale word never reads as valid
  task automatic write(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= '{1'b1, a, d};
    @(posedge clock);
    wr <= '{1'b0, ~a, ~d};
  endtask : write
endmodule : serial_host_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned RC = 20;
  typedef struct packed {
    cfg_loader_pkg::timing_cfg_t cfg;
    logic mux;
    logic half;
    logic ord;
  } row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic supply = 1'b0;
  logic spd = 1'b0;
  logic pdp = 1'b1;
  logic mux = 1'b0;
  logic ce = 1'b1;
  cfg_loader_pkg::timing_cfg_t nv = '{1'b1, 1'b1, 3'h3, 3'h3};
  cfg_loader_pkg::timing_cfg_t timing;
  cfg_loader_pkg::reg_write_t wr;
  logic half_eff, busy, ord_err;
  int n_errors = 0;
  int comparisons = 0;
  int nb;
  // Recommended settings first, then order cases with bypass on and off
  row_t rows [9] = '{
    '{'{1'b1, 1'b0, 3'h5, 3'h5}, 1'b0, 1'b0, 1'b0},
    '{'{1'b1, 1'b1, 3'h3, 3'h3}, 1'b0, 1'b1, 1'b0},
    '{'{1'b1, 1'b1, 3'h1, 3'h1}, 1'b1, 1'b0, 1'b0},
    '{'{1'b1, 1'b0, 3'h0, 3'h0}, 1'b0, 1'b0, 1'b0},
    '{'{1'b1, 1'b0, 3'h7, 3'h7}, 1'b0, 1'b0, 1'b0},
    '{'{1'b1, 1'b0, 3'h6, 3'h7}, 1'b0, 1'b0, 1'b0},
    '{'{1'b0, 1'b0, 3'h6, 3'h5}, 1'b0, 1'b0, 1'b0},
    '{'{1'b1, 1'b0, 3'h3, 3'h7}, 1'b0, 1'b0, 1'b0},
    '{'{1'b1, 1'b0, 3'h6, 3'h5}, 1'b0, 1'b0, 1'b1}};

  always #2.5 clock = ~clock;

  serial_host_model host_u (.clock(clock), .wr(wr));

  register_reset_and_output_timing_cfg #(.RESET_CYCLES(RC)) dut_u (
    .clock(clock), .rst_n(rst_n), .clock_en(ce),
    .analog_supply(supply), .serial_port_disable(spd),
    .power_down_pin(pdp), .mux_mode(mux), .wr(wr), .nv_defaults(nv),
    .timing_ff(timing), .half_delay_eff_ff(half_eff),
    .reset_busy_ff(busy), .order_error_ff(ord_err));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("errors=%0d compares=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Counts busy cycles over a window longer than one reset
  task automatic count_busy;
    #1 nb = int'(busy === 1'b1);
    repeat (RC + 10) begin
      @(posedge clock);
      #1 nb += int'(busy === 1'b1);
    end
  endtask : count_busy

  initial begin
    #20000 n_errors++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clock);
    #1 check(timing, 8'hb6);
    @(posedge clock) rst_n <= 1'b1;
    repeat (30) @(posedge clock);
    #1 check(busy, 1'b1);
    @(posedge clock) supply <= 1'b1;
    count_busy();
    check(timing, nv);
    foreach (rows[i]) begin
      @(posedge clock) mux <= rows[i].mux;
      host_u.write(5'h07, rows[i].cfg);
      @(posedge clock);
      #1 check(timing, rows[i].cfg);
      check(half_eff, rows[i].half);
      check(ord_err, rows[i].ord);
    end
    host_u.write(5'h0a, 8'h5b);
    count_busy();
    check(8'(nb), 8'h00);
    check(timing, rows[8].cfg);
    host_u.write(5'h0a, 8'h5a);
    count_busy();
    check(8'(nb), 8'(RC));
    check(timing, nv);
    host_u.write(5'h07, 8'h00);
    @(posedge clock) spd <= 1'b1;
    host_u.write(5'h07, 8'h55);
    #1 check(timing, 8'h00);
    @(posedge clock) pdp <= 1'b0;
    count_busy();
    check(8'(nb), 8'(RC));
    check(timing, nv);
    @(posedge clock) spd <= 1'b0;
    host_u.write(5'h0a, 8'h5a);
    host_u.write(5'h07, 8'h00);
    count_busy();
    check(timing, nv);
    // Frozen clock enable must swallow a config write
    @(posedge clock) ce <= 1'b0;
    host_u.write(5'h07, 8'h00);
    @(posedge clock) ce <= 1'b1;
    #1 check(timing, nv);
    // Reset in mid-run, then power-on load again
    @(posedge clock) rst_n <= 1'b0;
    #1 check(timing, 8'hb6);
    check(busy, 1'b1);
    @(posedge clock) rst_n <= 1'b1;
    count_busy();
    check(8'(nb), 8'(RC + 1));
    check(timing, nv);
    give_verdict();
  end
endmodule : tb_top
